// ===== hw/opsy_top.sv
/*
 * opsy_top: option pins, indicators and spindle-sync control over AHB-Lite.
 * Assumes one 200 MHz clock, an AHB-Lite master with word transfers only,
 * an external pull-up on the sync line and the motor controller outside.
 */
`timescale 1ns/100ps
`default_nettype none

module opsy_top #(
   parameter longint LOCK_CYC = opsy_pkg::LOCK_CYC,
   parameter longint REV_CYC  = opsy_pkg::REV_CYC
) (
   // clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output var  logic [31:0] hrdata,
   output var  logic        hreadyout,
   output var  logic        hresp,
   // option pins, active low
   input  wire logic        test_mode_select_n,
   input  wire logic        auto_start_n,
   input  wire logic        write_protect_n,
   input  wire logic        power_fail_n,
   // open-drain sync line
   input  wire logic        sync_in_n,
   output var  logic        sync_out_n,
   output var  logic        sync_oe,
   // link sync characters and spindle
   input  wire logic        link_sync_char,
   output var  logic        link_sync_send,
   input  wire logic        spindle_index,
   // indicators and motor
   output var  logic        activity_led_n,
   output var  logic        fault_led_n,
   output var  logic        prog_out,
   output var  logic        motor_run,
   output var  logic        sync_strobe
);
   // refuse counts that the lock and lag arithmetic cannot serve
   if (LOCK_CYC < 1 || REV_CYC < 256) begin : g_bad_counts
      $error("opsy_top: counts too small");
   end

   // ----------------------------------------------------------------------
   // input synchronisers
   // ----------------------------------------------------------------------
   logic [3:0] pins_s;
   logic       auto_s, wp_s, pfail_s, sync_s, sync_d_r;

   logic unused_tm;
   assign unused_tm = test_mode_select_n;

   opsy_sync2 #(.W(4), .RST(1'b1)) u_sync (
      .hclk    (hclk),
      .hresetn (hresetn),
      .d       ({auto_start_n, write_protect_n, power_fail_n, sync_in_n}),
      .q       (pins_s)
   );
   assign auto_s  = pins_s[3];
   assign wp_s    = pins_s[2];
   assign pfail_s = pins_s[1];
   assign sync_s  = pins_s[0];

   // ----------------------------------------------------------------------
   // ahb-lite slave
   // ----------------------------------------------------------------------
   logic [31:0] ctrl_r;
   logic [7:0]  wadr_r;
   logic        wen_r, cmd_wr, soft_rst, cmd_alter;
   logic [2:0]  init_r;
   logic        auto_r, start_r, refuse_r;
   logic        lock_r, media_ok;
   logic [31:0] status;
   logic [7:0]  revpos;
   logic        acc;

   assign acc       = hsel && hready && htrans[1];
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   // address phase capture for writes
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wen_r  <= 1'b0;
         wadr_r <= 8'h00;
      end else begin
         wen_r  <= acc && hwrite;
         wadr_r <= haddr[7:0];
      end
   end

   assign cmd_wr    = wen_r && (wadr_r == opsy_pkg::CMD_OFS);
   assign cmd_alter = cmd_wr && hwdata[opsy_pkg::CMD_WRITE_BIT];
   assign soft_rst  = cmd_wr && hwdata[opsy_pkg::CMD_SOFT_BIT];

   // control register; master sync control code is not stored
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_r <= opsy_pkg::CTRL_RESET;
      end else if (wen_r && wadr_r == opsy_pkg::CTRL_OFS) begin
         ctrl_r[15:2] <= hwdata[15:2];
         if (hwdata[1:0] != opsy_pkg::OPSY_MCTRL)
            ctrl_r[1:0] <= hwdata[1:0];
      end
   end

   assign status = {25'h0, refuse_r, ~pfail_s, ~wp_s, media_ok, lock_r,
                    motor_run, auto_r};

   // read data registered in the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (acc && !hwrite) begin
         unique case (haddr[7:0])
            opsy_pkg::CTRL_OFS:   hrdata <= ctrl_r;
            opsy_pkg::STATUS_OFS: hrdata <= status;
            opsy_pkg::REVPOS_OFS: hrdata <= {24'h0, revpos};
            default:              hrdata <= 32'h0000_0000;
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // auto-start and motor
   // ----------------------------------------------------------------------
   // sample at power-on, hard and soft reset
   // the last sample waits until the pin has crossed both synchroniser flops
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         init_r <= 3'h7;
         auto_r <= 1'b0;
      end else begin
         init_r <= {init_r[1:0], soft_rst};
         if (init_r[2])
            auto_r <= ~auto_s;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         start_r <= 1'b0;
      else if (soft_rst)
         start_r <= 1'b0;
      else if (wen_r && wadr_r == opsy_pkg::CTRL_OFS)
         start_r <= hwdata[opsy_pkg::CTRL_START_BIT];
   end

   assign motor_run = (auto_r || start_r) && pfail_s && (init_r == 3'h0);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         refuse_r <= 1'b0;
      else if (cmd_wr)
         refuse_r <= cmd_alter && (!wp_s || !media_ok);
   end

   // ----------------------------------------------------------------------
   // indicators
   // ----------------------------------------------------------------------
   // active low activity
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         activity_led_n <= 1'b1;
         fault_led_n    <= 1'b1;
         prog_out       <= 1'b0;
      end else begin
         activity_led_n <= ~(ctrl_r[opsy_pkg::CTRL_ACT_BIT] && pfail_s);
         fault_led_n    <= ~(ctrl_r[opsy_pkg::CTRL_FAULT_BIT] || !pfail_s);
         prog_out       <= ctrl_r[opsy_pkg::CTRL_PROG_BIT];
      end
   end

   // ----------------------------------------------------------------------
   // spindle sync
   // ----------------------------------------------------------------------
   opsy_pkg::opsy_mode_t mode;
   logic        hw_route, sync_ev, rev_ref;
   logic [7:0]  skew;
   logic [63:0] lock_cnt_r, rev_cnt_r, lag_cnt_r;
   logic [15:0] pulse_cnt_r;
   logic        lag_arm_r;

   assign mode     = opsy_pkg::opsy_mode_t'(ctrl_r[1:0]);
   assign hw_route = ctrl_r[opsy_pkg::CTRL_ROUTE_BIT];
   assign skew     = ctrl_r[opsy_pkg::CTRL_OFS_LSB +: 8];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         sync_d_r <= 1'b1;
      else
         sync_d_r <= sync_s;
   end
   assign sync_strobe = sync_d_r && !sync_s;

   assign sync_ev = (mode == opsy_pkg::OPSY_SLAVE) &&
                    (hw_route ? sync_strobe : link_sync_char);

   // revolution position counter, locked to the index
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         rev_cnt_r <= 64'h0;
      else if (spindle_index)
         rev_cnt_r <= 64'h0;
      else
         rev_cnt_r <= rev_cnt_r + 64'h1;
   end
   assign revpos = 8'((rev_cnt_r * 64'd256) / REV_CYC);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lag_cnt_r <= 64'h0;
         lag_arm_r <= 1'b0;
      end else if (sync_ev) begin
         lag_cnt_r <= (REV_CYC * 64'(skew)) / 64'd256;
         lag_arm_r <= 1'b1;
      end else if (lag_arm_r && lag_cnt_r != 64'h0) begin
         lag_cnt_r <= lag_cnt_r - 64'h1;
      end else begin
         lag_arm_r <= 1'b0;
      end
   end
   assign rev_ref = lag_arm_r && lag_cnt_r == 64'h0;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lock_cnt_r <= 64'h0;
         lock_r     <= 1'b0;
      end else if (mode != opsy_pkg::OPSY_SLAVE || !motor_run) begin
         lock_cnt_r <= 64'h0;
         lock_r     <= 1'b0;
      end else if (rev_ref && rev_cnt_r > 64'(opsy_pkg::LOCK_TOL_CYC)
                   && REV_CYC - rev_cnt_r > 64'(opsy_pkg::LOCK_TOL_CYC)) begin
         lock_cnt_r <= 64'h0;
         lock_r     <= 1'b0;
      end else if (lock_cnt_r >= LOCK_CYC - 64'h1) begin
         lock_r     <= 1'b1;
      end else begin
         lock_cnt_r <= lock_cnt_r + 64'h1;
      end
   end

   assign media_ok = motor_run && (mode != opsy_pkg::OPSY_SLAVE || lock_r);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pulse_cnt_r    <= 16'h0;
         link_sync_send <= 1'b0;
      end else begin
         link_sync_send <= 1'b0;
         if (mode == opsy_pkg::OPSY_MASTER && spindle_index && motor_run) begin
            if (hw_route)
               pulse_cnt_r <= 16'(opsy_pkg::SYNC_OUT_CYC);
            else
               link_sync_send <= 1'b1;
         end else if (pulse_cnt_r != 16'h0) begin
            pulse_cnt_r <= pulse_cnt_r - 16'h1;
         end
      end
   end

   assign sync_oe    = (mode == opsy_pkg::OPSY_MASTER) && hw_route && pulse_cnt_r != 16'h0;
   assign sync_out_n = 1'b0;

   // ----------------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------------
   sequence master_idx_s;
      mode == opsy_pkg::OPSY_MASTER && hw_route && spindle_index && motor_run;
   endsequence

   sync_pulse_a: assert property (@(posedge hclk) disable iff (!hresetn)
      master_idx_s ##1 !spindle_index |-> sync_oe)
      else $error("sync pulse not driven");
   nosync_quiet_a: assert property (@(posedge hclk) disable iff (!hresetn)
      mode == opsy_pkg::OPSY_NOSYNC |-> !link_sync_send && !sync_ev)
      else $error("no-sync mode active");
   slave_noout_a: assert property (@(posedge hclk) disable iff (!hresetn)
      mode != opsy_pkg::OPSY_MASTER |-> !sync_oe)
      else $error("sync driven while not master");
   edge_strobe_a: assert property (@(posedge hclk) disable iff (!hresetn)
      sync_strobe |-> $past(sync_s) && !sync_s)
      else $error("strobe without falling edge");
   media_block_a: assert property (@(posedge hclk) disable iff (!hresetn)
      mode == opsy_pkg::OPSY_SLAVE && !lock_r |-> !media_ok)
      else $error("media open before lock");
   wp_refuse_a: assert property (@(posedge hclk) disable iff (!hresetn)
      cmd_alter && !wp_s |=> refuse_r)
      else $error("write not refused");
   pfail_stop_a: assert property (@(posedge hclk) disable iff (!hresetn)
      !pfail_s |-> !motor_run ##1 !fault_led_n)
      else $error("power fail not handled");
   mctrl_rej_a: assert property (@(posedge hclk) disable iff (!hresetn)
      ctrl_r[1:0] != opsy_pkg::OPSY_MCTRL)
      else $error("control mode stored");
   prog_follow_a: assert property (@(posedge hclk) disable iff (!hresetn)
      ##1 prog_out == $past(ctrl_r[opsy_pkg::CTRL_PROG_BIT]))
      else $error("spare output wrong");
   lag_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
      sync_ev && skew == 8'h00 |=> rev_ref)
      else $error("reference not immediate without offset");
   lag_skew_a: assert property (@(posedge hclk) disable iff (!hresetn)
      sync_ev && skew != 8'h00 |=> !rev_ref)
      else $error("offset not applied to reference");
endmodule // opsy_top
`default_nettype wire

// ===== hw/opsy_pkg.sv
/*
 * opsy_pkg: register map, field layout, mode codes and timing counts of the
 * option-pin and spindle-sync block.
 * Assumes a 200 MHz system clock (5 ns period) and 32-bit AHB-Lite registers.
 */
package opsy_pkg;

   // ----------------------------------------------------------------------
   // clock and timing
   // ----------------------------------------------------------------------
   localparam int CLK_PERIOD_PS     = 5000;
   localparam int SYNC_OUT_WIDTH_NS = 2000;                 // driven sync pulse
   localparam int SYNC_IN_MIN_NS    = 1000;                 // external pulse min
   localparam int LOCK_TIME_MS      = 6000;                 // slave lock time
   localparam int LOCK_TOL_US       = 20;                   // locked tolerance
   localparam int PFAIL_WARN_MS     = 6;                    // warning lead time
   localparam int REV_PERIOD_US     = 8333;                 // nominal revolution
   localparam int SYNC_OUT_CYC      = (SYNC_OUT_WIDTH_NS * 1000) / CLK_PERIOD_PS;
   localparam int LOCK_TOL_CYC      = (LOCK_TOL_US * 1000000) / CLK_PERIOD_PS;
   localparam longint LOCK_CYC      = (64'(LOCK_TIME_MS) * 64'd1000000000) / CLK_PERIOD_PS;
   localparam longint REV_CYC       = (64'(REV_PERIOD_US) * 64'd1000000) / CLK_PERIOD_PS;

   // ----------------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------------
   localparam logic [7:0] CTRL_OFS   = 8'h00;
   localparam logic [7:0] STATUS_OFS = 8'h04;
   localparam logic [7:0] CMD_OFS    = 8'h08;
   localparam logic [7:0] REVPOS_OFS = 8'h0C;

   // ctrl field positions
   localparam int CTRL_MODE_LSB  = 0;   // spindle_sync_mode_field, 2 bits
   localparam int CTRL_ROUTE_BIT = 2;   // 1 = hard-wired line, 0 = link char
   localparam int CTRL_ACT_BIT   = 3;   // activity indicator
   localparam int CTRL_FAULT_BIT = 4;   // fault indicator
   localparam int CTRL_PROG_BIT  = 5;   // spare programmable output
   localparam int CTRL_START_BIT = 6;   // start/stop unit: start
   localparam int CTRL_OFS_LSB   = 8;   // rotational offset, 8 bits
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

   // status field positions
   localparam int ST_AUTO_BIT   = 0;
   localparam int ST_MOTOR_BIT  = 1;
   localparam int ST_LOCK_BIT   = 2;
   localparam int ST_MEDIA_BIT  = 3;
   localparam int ST_WP_BIT     = 4;
   localparam int ST_PFAIL_BIT  = 5;
   localparam int ST_REFUSE_BIT = 6;

   // command register fields
   localparam int CMD_WRITE_BIT = 0;    // command alters customer data
   localparam int CMD_SOFT_BIT  = 1;    // soft reset

   // ----------------------------------------------------------------------
   // sync mode codes
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      OPSY_NOSYNC = 2'h0,
      OPSY_SLAVE  = 2'h1,
      OPSY_MASTER = 2'h2,
      OPSY_MCTRL  = 2'h3
   } opsy_mode_t;

endpackage

// ===== hw/opsy_sync2.sv
/*
 * opsy_sync2: two-stage synchroniser for a vector of asynchronous pins.
 * Assumes inputs come from outside the hclk domain.
 */
`timescale 1ns/100ps
`default_nettype none
module opsy_sync2 #(
   parameter int W     = 1,
   parameter logic RST = 1'b1
) (
   // clock and reset
   input  wire logic         hclk,
   input  wire logic         hresetn,
   // data
   input  wire logic [W-1:0] d,
   output var  logic [W-1:0] q
);
   logic [W-1:0] meta_r;

   // refuse a vector with no bits
   if (W < 1) begin : g_bad_width
      $error("opsy_sync2: width below one");
   end

   // first flop feeds only the second
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         meta_r <= {W{RST}};
         q      <= {W{RST}};
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule // opsy_sync2
`default_nettype wire

// ===== sim/opsy_far_side.sv
/*
 * opsy_far_side: the other drives on the shared sync wire and the link.
 * Assumes the bench asks for one revolution reference by a one-cycle fire.
 */
`timescale 1ns/100ps
`default_nettype none
module opsy_far_side #(
   parameter int PULSE_CYC = 200
) (
   // clock
   input  wire logic hclk,
   // device side of the open-drain line
   input  wire logic sync_out_n,
   input  wire logic sync_oe,
   // reference request from the bench
   input  wire logic fire,
   // wire level and link character
   output var  logic sync_in_n,
   output var  logic link_sync_char
);
   int unsigned hold_cnt = 0;
   logic        drv_low;

   always @(posedge hclk) begin
      if (fire) hold_cnt <= PULSE_CYC;
      else if (hold_cnt != 0) hold_cnt <= hold_cnt - 1;
   end
   assign drv_low = (hold_cnt != 0);

   // wired line with pull-up, low while any party sinks it
   assign sync_in_n = !((sync_oe === 1'b1 && sync_out_n === 1'b0) || drv_low);

   initial link_sync_char = 1'b0;
   always @(posedge hclk) link_sync_char <= fire;
endmodule // opsy_far_side
`default_nettype wire

// ===== sim/opsy_top_tb_top.sv
/*
 * opsy_top_tb_top: self-checking bench of the option-pin and sync block.
 * Assumes one AHB-Lite slave (hready = hreadyout) and a far-side model.
 */
`timescale 1ns/100ps
`default_nettype none
module opsy_top_tb_top;
   // ----------------------------------------------------------------------
   // set-up, scoreboard and bus tasks
   // ----------------------------------------------------------------------
   localparam int LOCK_T = 100;
   localparam int REV_T = 1024;
   localparam int TIMEOUT = 40000;
   localparam logic [31:0] A_CTRL = {24'h000000, opsy_pkg::CTRL_OFS};
   localparam logic [31:0] A_ST = {24'h000000, opsy_pkg::STATUS_OFS};
   localparam logic [31:0] A_CMD = {24'h000000, opsy_pkg::CMD_OFS};
   localparam logic [31:0] START = 32'h1 << opsy_pkg::CTRL_START_BIT;
   localparam logic [31:0] WIRE = 32'h1 << opsy_pkg::CTRL_ROUTE_BIT;
   typedef struct {logic [31:0] e; logic [31:0] m; string n;} opsy_note_t;
   opsy_note_t  notes[$];
   int          num_errors = 0, samples_checked = 0, cycles = 0;
   int          n_oe, n_snd, n_stb, n_bad;
   logic [31:0] seed = 32'h000045D1, r, c;
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, rd_dph = 1'b0;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0]  htrans;
   logic        tmode_n, auto_n, wp_n, pfail_n, sync_in_n, sync_out_n, sync_oe;
   logic        link_char, link_send, spindle_index, fire, act_n, fault_n, prog;
   logic        motor_run, sync_strobe;

   opsy_top #(.LOCK_CYC(LOCK_T), .REV_CYC(REV_T)) i_opsy_top (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .test_mode_select_n(tmode_n),
      .auto_start_n(auto_n), .write_protect_n(wp_n), .power_fail_n(pfail_n),
      .sync_in_n(sync_in_n), .sync_out_n(sync_out_n), .sync_oe(sync_oe),
      .link_sync_char(link_char), .link_sync_send(link_send),
      .spindle_index(spindle_index), .activity_led_n(act_n), .fault_led_n(fault_n),
      .prog_out(prog), .motor_run(motor_run), .sync_strobe(sync_strobe));
   opsy_far_side #(.PULSE_CYC(opsy_pkg::SYNC_IN_MIN_NS * 1000 / opsy_pkg::CLK_PERIOD_PS))
   i_opsy_far_side (.hclk(hclk), .sync_out_n(sync_out_n), .sync_oe(sync_oe), .fire(fire),
      .sync_in_n(sync_in_n), .link_sync_char(link_char));

   function logic [31:0] nxt_rand();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         num_errors++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic pin(input string n, input logic e, input logic g);
      chk(n, {31'h0, e}, {31'h0, g});
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge hclk);
      #1;
   endtask
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1; haddr <= a; htrans <= 2'b10; hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
   endtask
   task automatic rd(input logic [31:0] a, e, m, input string n);
      notes.push_back('{e, m, n});
      bus(1'b0, a, 32'h0);
   endtask
   task automatic stbit(input int b, input logic v, input string n);
      rd(A_ST, 32'(v) << b, 32'h1 << b, n);
   endtask
   // one index pulse, optional far reference, then count outputs
   task automatic rev(input logic with_ref);
      n_oe = 0; n_snd = 0; n_stb = 0; n_bad = 0;
      @(posedge hclk);
      spindle_index <= 1'b1; fire <= with_ref;
      @(posedge hclk);
      spindle_index <= 1'b0; fire <= 1'b0;
      repeat (1000) begin
         @(posedge hclk);
         n_oe += (sync_oe === 1'b1) ? 1 : 0;
         n_snd += (link_send === 1'b1) ? 1 : 0;
         n_stb += (sync_strobe === 1'b1) ? 1 : 0;
         n_bad += (sync_oe === 1'b1 && sync_out_n !== 1'b0) ? 1 : 0;
      end
   endtask
   task conclude();
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   // read data taken at the end of each read data phase
   always @(posedge hclk) begin
      opsy_note_t nt;
      if (rd_dph && hreadyout === 1'b1) begin
         if (notes.size() == 0) chk("note queue", 32'h1, 32'h0);
         else begin
            nt = notes.pop_front();
            chk(nt.n, nt.e & nt.m, hrdata & nt.m);
            chk("hresp", 32'h0, {31'h0, hresp});
         end
      end
      if (hreadyout === 1'b1) rd_dph <= hsel && htrans[1] && !hwrite;
   end
   initial begin
      hclk = 1'b0;
      forever #2.5 hclk = ~hclk;
   end
   always @(posedge hclk) begin
      cycles++;
      if (cycles == TIMEOUT) begin
         num_errors++;
         $display("Error run length expected %0d seen %0d", TIMEOUT, cycles);
         conclude();
      end
   end

   // ----------------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------------
   initial begin
      hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
      hwdata = 32'h0; tmode_n = 1'b1; auto_n = 1'b0; wp_n = 1'b1; pfail_n = 1'b1;
      spindle_index = 1'b0; fire = 1'b0;
      cyc(7);
      pin("led act in reset", 1'b1, act_n); pin("motor in reset", 1'b0, motor_run);
      pin("oe in reset", 1'b0, sync_oe); pin("prog in reset", 1'b0, prog);
      @(posedge hclk) hresetn <= 1'b1;
      cyc(4);
      rd(A_CTRL, opsy_pkg::CTRL_RESET, 32'hFFFFFFFF, "ctrl reset");
      stbit(opsy_pkg::ST_AUTO_BIT, 1'b1, "auto captured");
      pin("motor auto", 1'b1, motor_run);
      auto_n <= 1'b1;
      cyc(5);
      pin("motor held", 1'b1, motor_run);
      bus(1'b1, A_CMD, 32'h1 << opsy_pkg::CMD_SOFT_BIT);
      cyc(5);
      stbit(opsy_pkg::ST_AUTO_BIT, 1'b0, "auto resampled");
      pin("motor stopped", 1'b0, motor_run);
      bus(1'b1, A_CTRL, START);
      cyc(2);
      pin("motor started", 1'b1, motor_run);
      $display("test autostart done");
      for (int i = 0; i < 4; i++) begin
         r = nxt_rand();
         tmode_n <= r[0];
         c = START | (r & 32'h00000038);
         bus(1'b1, A_CTRL, c);
         cyc(3);
         pin("activity led", ~c[opsy_pkg::CTRL_ACT_BIT], act_n);
         pin("fault led", ~c[opsy_pkg::CTRL_FAULT_BIT], fault_n);
         pin("spare out", c[opsy_pkg::CTRL_PROG_BIT], prog);
         rd(A_CTRL, c, 32'h0000FF7F, "ctrl readback");
         rd({24'h0, 8'h10 + {2'h0, r[7:4], 2'h0}}, 32'h0, 32'hFFFFFFFF, "unmapped");
      end
      $display("test indicators done");
      wp_n <= 1'b0;
      cyc(4);
      stbit(opsy_pkg::ST_MEDIA_BIT, 1'b1, "media ok");
      bus(1'b1, A_CMD, 32'h1 << opsy_pkg::CMD_WRITE_BIT);
      stbit(opsy_pkg::ST_REFUSE_BIT, 1'b1, "refused wp");
      wp_n <= 1'b1;
      cyc(4);
      bus(1'b1, A_CMD, 32'h1 << opsy_pkg::CMD_WRITE_BIT);
      stbit(opsy_pkg::ST_REFUSE_BIT, 1'b0, "accepted");
      $display("test write protect done");
      bus(1'b1, A_CTRL, START);
      bus(1'b1, A_CTRL, START | 32'h3);
      rd(A_CTRL, START, 32'h0000FF7F, "mode 3 kept out");
      bus(1'b1, A_CTRL, START | WIRE | 32'(opsy_pkg::OPSY_MASTER));
      rev(1'b0);
      chk("pulse cycles", opsy_pkg::SYNC_OUT_CYC, n_oe);
      chk("pulse level", 32'h0, n_bad);
      chk("no char on wire", 32'h0, n_snd);
      bus(1'b1, A_CTRL, START | 32'(opsy_pkg::OPSY_MASTER));
      rev(1'b0);
      chk("char count", 32'h1, n_snd);
      chk("no pulse on link", 32'h0, n_oe);
      bus(1'b1, A_CTRL, START | WIRE);
      rev(1'b1);
      chk("nosync sends", 32'h0, n_oe + n_snd);
      $display("test master done");
      bus(1'b1, A_CTRL, START | WIRE | 32'h00004000 | 32'(opsy_pkg::OPSY_SLAVE));
      bus(1'b1, A_CMD, 32'h1 << opsy_pkg::CMD_WRITE_BIT);
      stbit(opsy_pkg::ST_REFUSE_BIT, 1'b1, "refused unlocked");
      for (int k = 0; k < 10; k++) begin
         rev(1'b1);
         chk("slave strobe", 32'h1, n_stb);
         chk("slave drives", 32'h0, n_oe);
      end
      stbit(opsy_pkg::ST_LOCK_BIT, 1'b1, "locked");
      bus(1'b1, A_CMD, 32'h1 << opsy_pkg::CMD_WRITE_BIT);
      stbit(opsy_pkg::ST_REFUSE_BIT, 1'b0, "accepted locked");
      bus(1'b1, A_CTRL, START | 32'(opsy_pkg::OPSY_SLAVE));
      cyc(opsy_pkg::LOCK_TOL_CYC + 100);
      @(posedge hclk) fire <= 1'b1;
      @(posedge hclk) fire <= 1'b0;
      cyc(8);
      stbit(opsy_pkg::ST_LOCK_BIT, 1'b0, "lock lost late char");
      cyc(LOCK_T + 20);
      stbit(opsy_pkg::ST_LOCK_BIT, 1'b1, "relocked on char");
      $display("test slave done");
      pfail_n <= 1'b0;
      cyc(4);
      stbit(opsy_pkg::ST_PFAIL_BIT, 1'b1, "power fail");
      pfail_n <= 1'b1;
      auto_n <= 1'b0;
      @(posedge hclk) hresetn <= 1'b0;
      cyc(3);
      @(posedge hclk) hresetn <= 1'b1;
      cyc(4);
      stbit(opsy_pkg::ST_AUTO_BIT, 1'b1, "auto hard reset");
      pin("motor hard reset", 1'b1, motor_run);
      $display("test power and reset done");
      cyc(2);
      conclude();
   end
endmodule // opsy_top_tb_top
`default_nettype wire
